// File: src/ilmp_params.svh
// offsets, field positions and reset values of the identity/led/mib/phy bank
`ifndef ILMP_PARAMS_SVH
`define ILMP_PARAMS_SVH
// bank numbers that hold registers of this block
`define ILMP_BANK_ID     6'd32
`define ILMP_BANK_IND    6'd42
`define ILMP_BANK_PHY    6'd45
`define ILMP_BANK_SPC    6'd49
// register indices, byte address is four times the index
`define ILMP_IDX_BANKSEL 4'hE
`define ILMP_IDX_ID      4'h0
`define ILMP_IDX_GCTL    4'hA
`define ILMP_IDX_INDIRECT_ACCESS_CONTROL    4'h0
`define ILMP_IDX_D1      4'h2
`define ILMP_IDX_D2      4'h4
`define ILMP_IDX_D3      4'h6
`define ILMP_IDX_DLO     4'h8
`define ILMP_IDX_DHI     4'hA
`define ILMP_IDX_PHY     4'h0
`define ILMP_IDX_SPC     4'h2
// global control fields
`define ILMP_GC_SEL_HI   15
`define ILMP_GC_SEL_LO   9
// indirect control fields
`define ILMP_IA_DIR      12
`define ILMP_IA_TBL_HI   11
`define ILMP_IA_TBL_LO   10
`define ILMP_IA_ADR_HI   9
`define ILMP_TBL_MIB     2'b11
// phy basic control fields
`define ILMP_PB_SPEED    13
`define ILMP_PB_AN       12
`define ILMP_PB_PDN      11
`define ILMP_PB_RESTART  9
`define ILMP_PB_FDX      8
`define ILMP_PB_XALG     5
`define ILMP_PB_FXOVR    4
`define ILMP_PB_DXOVR    3
`define ILMP_PB_DTX      1
`define ILMP_PB_DLED     0
`define ILMP_PB_WMASK    16'h7B3F
// reset values
`define ILMP_RST_BANK    6'h00
`define ILMP_RST_GCTL    16'h0835
`define ILMP_RST_INDIRECT_ACCESS_CONTROL    16'h0000
`define ILMP_RST_DATA    16'h0000
`define ILMP_RST_PHY     16'h1020
`endif

// File: src/ilmp_pkg.sv
// types shared by the identity/led/mib/phy register bank
package ilmp_pkg;
  // which register an access hits
  typedef enum logic [3:0] {
    ILMP_RID_NONE, ILMP_RID_BANK, ILMP_RID_ID, ILMP_RID_GCTL,
    ILMP_RID_INDIRECT_ACCESS_CONTROL, ILMP_RID_RSVD, ILMP_RID_DLO, ILMP_RID_DHI,
    ILMP_RID_PHY, ILMP_RID_SPC
  } ilmp_rid_t;
  // one indirect table command
  typedef struct packed {
    logic        valid;
    logic        read;
    logic [1:0]  table_sel;
    logic [9:0]  addr;
    logic [31:0] wdata;
  } ilmp_cmd_t;
  // live port state feeding the indicators
  typedef struct packed {
    logic link;
    logic act;
    logic fdx;
    logic col;
    logic spd100;
  } ilmp_link_t;
  // decoded phy controls
  typedef struct packed {
    logic force_100;
    logic an_enable;
    logic power_down;
    logic full_duplex;
    logic crossover_algorithm_select;
    logic force_crossed;
    logic disable_crossover;
    logic disable_tx;
    logic disable_indicators;
  } ilmp_phyctl_t;
  // whole state of the register bank
  typedef struct packed {
    logic [5:0]  bank;
    logic [15:0] gctl;
    logic [15:0] indirect_access_control;
    logic [15:0] dlo;
    logic [15:0] dhi;
    logic [15:0] phy;
    ilmp_cmd_t   cmd;
    logic        restart;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  ind;
  } ilmp_state_t;
endpackage

// File: src/ilmp_regs.sv
// apb register bank: identity, indicator select, indirect mib port, phy ctl
//
// Summary of operation
// - identity word read-only: family, part, revision
// - select code from global bits 15 and 9
// - codes 00 and 01 indicator mappings
// - code 10 mapping, code 11 undefined
// - each indirect control write launches one access
// - bit 12: one reads, zero writes
// - table field 11 selects counters only
// - low ten bits address the counter
// - data window 32 bits over two words
// - first three data words read zero
// - bit 13 forces speed without autoneg
// - bit 12 enables autoneg, resets to one
// - writing one to bit 9 restarts autoneg
// - bit 8 selects full or half duplex
// - bit 5 picks crossover algorithm, resets one
// - bits 4, 3 force or disable crossover
// - bits 1, 0 disable transmitter, indicators
// - bank select reachable at 0xE everywhere
//
// The APB slave port was chosen for this implementation.
`include "ilmp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ilmp_regs
  import ilmp_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
  parameter logic [3:0] PART_CODE   = 4'h3,  // arbitrary value
  parameter logic [2:0] REV_CODE    = 3'h2   // arbitrary value
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire ilmp_link_t        link_state,
  output logic [3:0]             port_indicator,
  output ilmp_cmd_t              mib_cmd,
  input  wire logic              mib_rvalid,
  input  wire logic [31:0]       mib_rdata,
  output ilmp_phyctl_t           phy_ctrl,
  output logic                   an_restart
);

  // the word index needs four address bits above the byte lanes
  if (ADDR_W < 6) begin : g_bad_addr
    $error("ADDR_W must be at least 6");
  end

  localparam ilmp_state_t ST_RST = '{
    bank:    `ILMP_RST_BANK,
    gctl:    `ILMP_RST_GCTL,
    indirect_access_control:    `ILMP_RST_INDIRECT_ACCESS_CONTROL,
    dlo:     `ILMP_RST_DATA,
    dhi:     `ILMP_RST_DATA,
    phy:     `ILMP_RST_PHY,
    default: '0
  };

  // basic control bit to special-control bit, -1 where none, bit 15 first
  localparam int SPC_POS [15:0] = '{
    -1, -1, 6, 7, 11, -1, 13, 5,
    -1, -1, -1, 9, 10, 12, 14, 15
  };

  ilmp_state_t s_reg;      // registered state
  ilmp_state_t s_next;     // next state
  ilmp_rid_t   rid;        // register hit by the current access
  logic        acc;        // access phase of a transfer
  logic        wr;         // write commits at this edge
  logic [15:0] wmask;      // byte enables of the low half
  logic [15:0] wval;       // low half of write data

  // map an address in the active bank to a register
  function automatic ilmp_rid_t reg_decode(
    input logic [5:0]        bank,
    input logic [ADDR_W-1:0] addr
  );
    logic [3:0] idx;
    logic       ok;
    idx = addr[5:2];
    ok  = (addr[1:0] == 2'b00) && (addr >> 6 == '0);
    reg_decode = ILMP_RID_NONE;
    if (!ok) begin
      reg_decode = ILMP_RID_NONE;
    // bank select answers in every bank, reserved banks too
    end else if (idx == `ILMP_IDX_BANKSEL) begin
      reg_decode = ILMP_RID_BANK;
    end else if (bank == `ILMP_BANK_ID) begin
      if (idx == `ILMP_IDX_ID) begin
        reg_decode = ILMP_RID_ID;
      end else if (idx == `ILMP_IDX_GCTL) begin
        reg_decode = ILMP_RID_GCTL;
      end
    end else if (bank == `ILMP_BANK_IND) begin
      unique case (idx)
        `ILMP_IDX_INDIRECT_ACCESS_CONTROL: reg_decode = ILMP_RID_INDIRECT_ACCESS_CONTROL;
        `ILMP_IDX_D1,
        `ILMP_IDX_D2,
        `ILMP_IDX_D3:   reg_decode = ILMP_RID_RSVD;
        `ILMP_IDX_DLO:  reg_decode = ILMP_RID_DLO;
        `ILMP_IDX_DHI:  reg_decode = ILMP_RID_DHI;
        default:        reg_decode = ILMP_RID_NONE;
      endcase
    end else if (bank == `ILMP_BANK_PHY) begin
      if (idx == `ILMP_IDX_PHY) begin
        reg_decode = ILMP_RID_PHY;
      end
    end else if (bank == `ILMP_BANK_SPC) begin
      if (idx == `ILMP_IDX_SPC) begin
        reg_decode = ILMP_RID_SPC;
      end
    end
  endfunction

  // gather the aliased bits into special-control layout
  function automatic logic [15:0] phy_to_spc(input logic [15:0] w);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (SPC_POS[i] >= 0) begin
        r[SPC_POS[i]] = w[i];
      end
    end
    phy_to_spc = r;
  endfunction

  // apply a special-control write onto the basic word
  function automatic logic [15:0] spc_to_phy(
    input logic [15:0] cur,
    input logic [15:0] w,
    input logic [15:0] m
  );
    logic [15:0] r;
    r = cur;
    for (int i = 0; i < 16; i++) begin
      if (SPC_POS[i] >= 0) begin
        if (m[SPC_POS[i]]) begin
          r[i] = w[SPC_POS[i]];
        end
      end
    end
    spc_to_phy = r;
  endfunction

  // read value of the addressed register
  function automatic logic [15:0] read_mux(
    input ilmp_rid_t   r,
    input ilmp_state_t st
  );
    unique case (r)
      ILMP_RID_BANK: read_mux = {10'h000, st.bank};
      ILMP_RID_ID:   read_mux = {FAMILY_CODE, PART_CODE, REV_CODE, 1'b0};
      ILMP_RID_GCTL: read_mux = st.gctl;
      ILMP_RID_INDIRECT_ACCESS_CONTROL: read_mux = st.indirect_access_control;
      ILMP_RID_RSVD: read_mux = 16'h0000;
      ILMP_RID_DLO:  read_mux = st.dlo;
      ILMP_RID_DHI:  read_mux = st.dhi;
      ILMP_RID_PHY:  read_mux = st.phy;
      ILMP_RID_SPC:  read_mux = phy_to_spc(st.phy);
      ILMP_RID_NONE: read_mux = 16'h0000;
    endcase
  endfunction

  // access decode and write strobe
  always_comb begin
    acc   = psel && penable;
    rid   = reg_decode(s_reg.bank, paddr);
    wr    = acc && s_reg.pready && pwrite && (rid != ILMP_RID_NONE);
    wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wval  = pwdata[15:0];
  end

  // next-state logic of the whole bank
  always_comb begin
    logic [1:0] sel;
    logic       la;
    s_next = s_reg;
    sel = 2'b00;
    la = 1'b0;
    // one-cycle pulses fall by default
    s_next.cmd.valid = 1'b0;
    s_next.restart = 1'b0;
    // apb answer one cycle into the access phase
    if (acc && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.pslverr = (rid == ILMP_RID_NONE);
      s_next.prdata = pwrite ? 32'h0000_0000
                             : {16'h0000, read_mux(rid, s_reg)};
    end else begin
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      s_next.prdata = 32'h0000_0000;
    end
    // register writes commit when pready is sampled high
    if (wr) begin
      unique case (rid)
        ILMP_RID_BANK: begin
          if (pstrb[0]) begin
            s_next.bank = pwdata[5:0];
          end
        end
        ILMP_RID_GCTL: begin
          s_next.gctl = (s_reg.gctl & ~wmask) | (wval & wmask);
        end
        ILMP_RID_INDIRECT_ACCESS_CONTROL: begin
          s_next.indirect_access_control = (s_reg.indirect_access_control & ~wmask) | (wval & wmask);
          s_next.cmd.valid = 1'b1;
          s_next.cmd.read = s_next.indirect_access_control[`ILMP_IA_DIR];
          s_next.cmd.table_sel =
            s_next.indirect_access_control[`ILMP_IA_TBL_HI:`ILMP_IA_TBL_LO];
          s_next.cmd.addr = s_next.indirect_access_control[`ILMP_IA_ADR_HI:0];
          s_next.cmd.wdata = {s_reg.dhi, s_reg.dlo};
        end
        ILMP_RID_DLO: begin
          s_next.dlo = (s_reg.dlo & ~wmask) | (wval & wmask);
        end
        ILMP_RID_DHI: begin
          s_next.dhi = (s_reg.dhi & ~wmask) | (wval & wmask);
        end
        ILMP_RID_PHY: begin
          s_next.phy = (s_reg.phy & ~(wmask & `ILMP_PB_WMASK))
                     | (wval & wmask & `ILMP_PB_WMASK);
        end
        ILMP_RID_SPC: begin
          // alias writes land in the basic word
          s_next.phy = spc_to_phy(s_reg.phy, wval, wmask);
        end
        default: begin
          s_next.bank = s_reg.bank;
        end
      endcase
      // restart pulse when bit 9 is one after a phy or alias write
      if (s_next.phy[`ILMP_PB_RESTART] &&
          (rid == ILMP_RID_PHY || rid == ILMP_RID_SPC)) begin
        s_next.restart = 1'b1;
      end
    end
    // table read data wins over a same-cycle host write
    if (mib_rvalid) begin
      s_next.dlo = mib_rdata[15:0];
      s_next.dhi = mib_rdata[31:16];
    end
    sel = {s_reg.gctl[`ILMP_GC_SEL_HI], s_reg.gctl[`ILMP_GC_SEL_LO]};
    la = link_state.link && !link_state.act;
    // indicator mapping per select code
    unique case (sel)
      2'b00: s_next.ind = {1'b0, la,
                           link_state.fdx || link_state.col,
                           link_state.spd100};
      2'b01: s_next.ind = {1'b0, la && link_state.spd100,
                           la && !link_state.spd100,
                           link_state.fdx};
      2'b10: s_next.ind = {link_state.act, link_state.link,
                           link_state.fdx || link_state.col,
                           link_state.spd100};
      2'b11: s_next.ind = 4'h0;
    endcase
    if (s_reg.phy[`ILMP_PB_DLED]) begin
      s_next.ind = 4'h0;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign port_indicator = s_reg.ind;
  assign mib_cmd = s_reg.cmd;
  assign an_restart = s_reg.restart;
  assign phy_ctrl.force_100 = s_reg.phy[`ILMP_PB_SPEED];
  assign phy_ctrl.an_enable = s_reg.phy[`ILMP_PB_AN];
  assign phy_ctrl.power_down = s_reg.phy[`ILMP_PB_PDN];
  assign phy_ctrl.full_duplex = s_reg.phy[`ILMP_PB_FDX];
  assign phy_ctrl.crossover_algorithm_select = s_reg.phy[`ILMP_PB_XALG];
  assign phy_ctrl.force_crossed = s_reg.phy[`ILMP_PB_FXOVR];
  assign phy_ctrl.disable_crossover = s_reg.phy[`ILMP_PB_DXOVR];
  assign phy_ctrl.disable_tx = s_reg.phy[`ILMP_PB_DTX];
  assign phy_ctrl.disable_indicators = s_reg.phy[`ILMP_PB_DLED];

  // checks on the bank behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  chk_id_value: assert property (
    acc && !pready && !pwrite && rid == ILMP_RID_ID
    |=> prdata == {16'h0000, FAMILY_CODE, PART_CODE, REV_CODE, 1'b0})
    else $error("identity word wrong");

  chk_led_code00: assert property (
    s_reg.gctl[15] == 1'b0 && s_reg.gctl[9] == 1'b0 && !s_reg.phy[0]
    |=> port_indicator[0] == $past(link_state.spd100)
        && port_indicator[3] == 1'b0)
    else $error("code 00 mapping wrong");

  chk_led_code10: assert property (
    s_reg.gctl[15] && !s_reg.gctl[9] && !s_reg.phy[0]
    |=> port_indicator[3] == $past(link_state.act)
        && port_indicator[2] == $past(link_state.link))
    else $error("code 10 mapping wrong");

  chk_cmd_launch: assert property (
    wr && rid == ILMP_RID_INDIRECT_ACCESS_CONTROL
    |=> mib_cmd.valid ##1 !mib_cmd.valid)
    else $error("indirect command not one pulse");

  chk_cmd_fields: assert property (
    wr && rid == ILMP_RID_INDIRECT_ACCESS_CONTROL && pstrb == 4'hF
    |=> mib_cmd.read == $past(pwdata[12])
        && mib_cmd.table_sel == $past(pwdata[11:10])
        && mib_cmd.addr == $past(pwdata[9:0]))
    else $error("indirect command fields wrong");

  chk_rsvd_data: assert property (
    acc && !pready && !pwrite && rid == ILMP_RID_RSVD
    |=> prdata == 32'h0000_0000 && !pslverr)
    else $error("reserved data word not zero");

  chk_an_restart: assert property (
    wr && rid == ILMP_RID_PHY && pstrb[1] && pwdata[9]
    |=> an_restart ##1 !an_restart)
    else $error("restart pulse missing");

  chk_phy_alias: assert property (
    wr && rid == ILMP_RID_SPC && pstrb[0]
    |=> phy_ctrl.an_enable == $past(pwdata[7]))
    else $error("alias write lost");

  chk_phy_rsvd: assert property (
    s_reg.phy[15] == 1'b0 && s_reg.phy[10] == 1'b0
    && s_reg.phy[7] == 1'b0 && s_reg.phy[6] == 1'b0)
    else $error("unsupported phy bit set");

  chk_bank_sel: assert property (
    wr && rid == ILMP_RID_BANK && pstrb[0]
    |=> s_reg.bank == $past(pwdata[5:0]))
    else $error("bank select not reachable");

endmodule

`default_nettype wire

// File: bench/ilmp_regs_tb.sv
// self-checking bench for the identity, indicator, indirect and phy bank
`include "ilmp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ilmp_regs_tb;
  import ilmp_pkg::*;
  localparam logic [7:0] FAM = 8'h5A; // arbitrary value
  localparam logic [3:0] PRT = 4'h3;  // arbitrary value
  localparam logic [2:0] REV = 3'h2;  // arbitrary value
  logic        sys_clk, resetn, psel, penable, pwrite, mib_rvalid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mib_rdata, r, rv;
  logic [3:0]  pstrb, port_indicator;
  logic        pready, pslverr, an_restart, e;
  ilmp_link_t   link_state;
  ilmp_cmd_t    mib_cmd;
  ilmp_phyctl_t phy_ctrl;
  logic [15:0] w, dl, dh, ia;
  int          mismatches, n_checks, seed, cnt;

  // device under test
  ilmp_regs #(.ADDR_W(12), .FAMILY_CODE(FAM), .PART_CODE(PRT),
    .REV_CODE(REV)) u_ilmp_regs (.sys_clk(sys_clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_state(link_state),
    .port_indicator(port_indicator), .mib_cmd(mib_cmd),
    .mib_rvalid(mib_rvalid), .mib_rdata(mib_rdata), .phy_ctrl(phy_ctrl),
    .an_restart(an_restart));

  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // byte address of a register index
  function automatic logic [11:0] ad(input logic [3:0] idx);
    return {6'h00, idx, 2'b00};
  endfunction

  // expected indicator pattern for a select code and port state
  function automatic logic [3:0] ind_exp(input logic [1:0] c,
                                         input ilmp_link_t s);
    logic la;
    la = s.link & ~s.act;
    case (c)
      2'b00: return {1'b0, la, s.fdx | s.col, s.spd100};
      2'b01: return {1'b0, la & s.spd100, la & ~s.spd100, s.fdx};
      2'b10: return {s.act, s.link, s.fdx | s.col, s.spd100};
      default: return 4'h0;
    endcase
  endfunction

  // expected decoded phy controls from a phy word
  function automatic logic [8:0] phy_dec(input logic [15:0] v);
    return {v[13], v[12], v[11], v[8], v[5], v[4], v[3], v[1], v[0]};
  endfunction

  // one comparison, reported at once on mismatch
  task automatic cmp(input logic [47:0] g, input logic [47:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // one apb transfer: setup, access, wait for pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask

  // read a register and compare data and error flag
  task automatic rd(input logic [11:0] a, input logic [15:0] x);
    apb(1'b0, a, 32'h0000_0000);
    cmp({15'h0000, e, r}, {17'h0_0000, 15'h0000, x});
  endtask

  task automatic bank(input logic [5:0] b);
    wr(ad(`ILMP_IDX_BANKSEL), {10'h000, b});
  endtask

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim;
  end

  initial begin
    seed = 32'h069b;
    resetn = 1'b0;
    {psel, penable, pwrite, mib_rvalid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mib_rdata = 32'h0000_0000;
    pstrb = 4'hF;
    link_state = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values and read-only identity
    rd(ad(`ILMP_IDX_BANKSEL), 16'h0000);
    bank(`ILMP_BANK_ID);
    rd(ad(`ILMP_IDX_ID), {FAM, PRT, REV, 1'b0});
    wr(ad(`ILMP_IDX_ID), 16'hFFFF);
    rd(ad(`ILMP_IDX_ID), {FAM, PRT, REV, 1'b0});
    rd(ad(`ILMP_IDX_GCTL), 16'h0835);
    bank(`ILMP_BANK_PHY);
    rd(ad(`ILMP_IDX_PHY), 16'h1020);
    cmp(48'(phy_ctrl), 48'(phy_dec(16'h1020)));
    $display("test reset done");
    // every select code with random port state
    bank(`ILMP_BANK_ID);
    for (int c = 0; c < 4; c++) begin
      repeat (3) begin
        w = 16'($random(seed));
        w = (w & 16'h7DFF) | {c[1], 5'h00, c[0], 9'h000};
        wr(ad(`ILMP_IDX_GCTL), w);
        link_state <= ilmp_link_t'(5'($random(seed)));
        repeat (3) @(posedge sys_clk);
        rd(ad(`ILMP_IDX_GCTL), w);
        cmp(48'(port_indicator), 48'(ind_exp(c[1:0], link_state)));
      end
    end
    // indicator disable through the phy word
    wr(ad(`ILMP_IDX_GCTL), 16'h8000);
    link_state <= '1;
    bank(`ILMP_BANK_PHY);
    wr(ad(`ILMP_IDX_PHY), 16'h1021);
    repeat (3) @(posedge sys_clk);
    cmp(48'(port_indicator), 48'h0);
    wr(ad(`ILMP_IDX_PHY), 16'h1020);
    repeat (3) @(posedge sys_clk);
    cmp(48'(port_indicator), 48'hF);
    $display("test indicators done");
    // indirect commands, window and reserved words
    bank(`ILMP_BANK_IND);
    for (int i = 1; i < 4; i++) begin
      wr(ad(4'(2 * i)), 16'hFFFF);
      rd(ad(4'(2 * i)), 16'h0000);
    end
    repeat (8) begin
      dl = 16'($random(seed));
      dh = 16'($random(seed));
      ia = {3'b000, 1'($random(seed)), `ILMP_TBL_MIB, 10'($random(seed))};
      wr(ad(`ILMP_IDX_DLO), dl);
      wr(ad(`ILMP_IDX_DHI), dh);
      wr(ad(`ILMP_IDX_INDIRECT_ACCESS_CONTROL), ia);
      @(posedge sys_clk);
      cmp(48'(mib_cmd), {2'b00, 1'b1, ia[12:0], dh, dl});
      @(posedge sys_clk);
      cmp(48'(mib_cmd.valid), 48'h0);
      rd(ad(`ILMP_IDX_INDIRECT_ACCESS_CONTROL), ia);
      if (ia[12]) begin
        rv = $random(seed);
        mib_rvalid <= 1'b1;
        mib_rdata  <= rv;
        @(posedge sys_clk);
        mib_rvalid <= 1'b0;
        dl = rv[15:0];
        dh = rv[31:16];
      end
      rd(ad(`ILMP_IDX_DLO), dl);
      rd(ad(`ILMP_IDX_DHI), dh);
    end
    $display("test indirect done");
    // phy word fields, restart pulse, alias and byte lanes
    bank(`ILMP_BANK_PHY);
    repeat (8) begin
      w = 16'($random(seed));
      wr(ad(`ILMP_IDX_PHY), w);
      cnt = 0;
      repeat (3) begin
        @(posedge sys_clk);
        if (an_restart === 1'b1) cnt++;
      end
      cmp(48'(cnt), 48'(w[9]));
      rd(ad(`ILMP_IDX_PHY), w & 16'h7B3F);
      cmp(48'(phy_ctrl), 48'(phy_dec(w)));
    end
    wr(ad(`ILMP_IDX_PHY), 16'h0000);
    bank(`ILMP_BANK_SPC);
    wr(ad(`ILMP_IDX_SPC), 16'h4040);
    rd(ad(`ILMP_IDX_SPC), 16'h4040);
    bank(`ILMP_BANK_PHY);
    rd(ad(`ILMP_IDX_PHY), 16'h2002);
    pstrb <= 4'b0010;
    wr(ad(`ILMP_IDX_PHY), 16'hFFFF);
    pstrb <= 4'hF;
    rd(ad(`ILMP_IDX_PHY), 16'h7B02);
    $display("test phy done");
    // reserved bank keeps bank select, refuses the rest
    bank(6'd35);
    rd(ad(`ILMP_IDX_BANKSEL), 16'd35);
    apb(1'b0, ad(4'h0), 32'h0000_0000);
    cmp(48'(e), 48'h1);
    apb(1'b0, 12'h039, 32'h0000_0000);
    cmp(48'(e), 48'h1);
    bank(`ILMP_BANK_ID);
    rd(ad(`ILMP_IDX_ID), {FAM, PRT, REV, 1'b0});
    $display("test banks done");
    end_sim;
  end
endmodule
`default_nettype wire
